//--- dv/spt_partner.sv
// Far-side serial peripheral model for master-mode traffic
`timescale 1ns/1ps
module spt_partner (
   input  wire logic       clk_in,
   input  wire logic       sclk_in,
   input  wire logic       cs_n_in,
   input  wire logic       mosi_in,
   input  wire logic       pol_in,
   input  wire logic       pha_in,
   input  wire logic       slow_in,
   input  wire logic [7:0] tx_byte_in,
   output logic            miso_out,
   output logic [7:0]      rx_byte_out
);
   logic       sclk_r = 1'b0;
   logic       last_r = 1'b0;
   logic [2:0] idx_r = 3'h0;
   logic [2:0] idx_d_r = 3'h0;
   logic [7:0] rx_r = 8'h00;
   logic       lead, samp;
   assign lead = (sclk_in != sclk_r) && (sclk_in != pol_in);
   assign samp = (sclk_in != sclk_r) && (lead != pha_in);
   // Released line toggles so a stale bit can never look valid
   assign miso_out = cs_n_in ? ~last_r : tx_byte_in[3'h7 - (slow_in ? idx_d_r : idx_r)];
   assign rx_byte_out = rx_r;
   always @(posedge clk_in) begin
      sclk_r <= sclk_in;
      last_r <= miso_out;
      idx_d_r <= idx_r;
      if (cs_n_in) begin
         idx_r <= 3'h0;
      end else if (samp) begin
         rx_r <= {rx_r[6:0], mosi_in};
         idx_r <= idx_r + 3'h1;
      end
   end
endmodule

//--- dv/spt_properties.sv
// Checker bound to the serial transfer controller
`timescale 1ns/1ps
module spt_properties (
   input wire logic                  clk_in,
   input wire logic                  arst_n_in,
   input wire spt_pkg::spt_apb_req_t apb_req_in,
   input wire spt_pkg::spt_apb_rsp_t apb_rsp_out,
   input wire spt_pkg::spt_pins_t    pins_out,
   input wire logic                  spi_event_out
);
   import spt_pkg::*;
   spt_ctl_t   ctl_r;
   logic [2:0] age_r;
   logic       wr_ctl, calm, run;
   // Shadow control word; checks wait until the pins have caught up
   assign wr_ctl = apb_req_in.psel & apb_req_in.penable & apb_req_in.pwrite
                   & apb_rsp_out.pready & (apb_req_in.paddr == REG_CONTROL);
   assign calm = (age_r == 3'h7);
   assign run = calm & ctl_r.spi_enable & ctl_r.controller_role_select;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ctl_r <= '0;
         age_r <= 3'h0;
      end else if (wr_ctl) begin
         ctl_r <= spt_ctl_t'(apb_req_in.pwdata[15:0]);
         age_r <= 3'h0;
      end else if (!calm) begin
         age_r <= age_r + 3'h1;
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   chk_idle_level: assert property (
      run && pins_out.cs_n |-> pins_out.sclk == ctl_r.clock_idle_polarity)
      else $error("serial clock off idle level");
   chk_wired_zero: assert property (
      calm && ctl_r.wired_or_outputs |-> !pins_out.mosi && !pins_out.miso)
      else $error("wired-or data value driven high");
   chk_miso_off: assert property (
      calm && !ctl_r.slave_out_drive_en |-> !pins_out.miso_oe)
      else $error("slave output driven while disabled");
   chk_slave_no_clock: assert property (
      calm && !ctl_r.controller_role_select |-> !pins_out.sclk_oe && !pins_out.cs_n_oe)
      else $error("slave drives clock or select");
   chk_off_still: assert property (
      calm && !ctl_r.spi_enable |-> $stable(pins_out.sclk) && $stable(pins_out.cs_n))
      else $error("serial pins move while disabled");
   chk_purge_quiet: assert property (
      calm && ctl_r.rx_fifo_purge |-> !spi_event_out)
      else $error("event raised during receive purge");
   chk_byte_hold: assert property (
      run && $fell(pins_out.cs_n) |-> !pins_out.cs_n [*8])
      else $error("select released inside a byte");
   chk_stall_gap: assert property (
      run && !ctl_r.continuous_transfer && $rose(pins_out.cs_n) |-> pins_out.cs_n [*2])
      else $error("no stall between single bytes");
endmodule
bind spt_transfer_control spt_properties u_props (
   .clk_in(clk_in), .arst_n_in(arst_n_in), .apb_req_in(apb_req_in),
   .apb_rsp_out(apb_rsp_out), .pins_out(pins_out), .spi_event_out(spi_event_out));

//--- dv/testbench.sv
// Self-checking testbench for the serial transfer controller
`timescale 1ns/1ps
module testbench;
   import spt_pkg::*;
   logic         clk_in = 1'b0;
   logic         arst_n_in = 1'b0;
   spt_apb_req_t req = '0;
   spt_apb_rsp_t rsp;
   spt_pins_t    pins;
   spt_ctl_t     c = '0;
   logic         ev, err, slow = 1'b0;
   logic         s_sclk = 1'b0, s_cs = 1'b1, s_mosi = 1'b0;
   logic         sclk_w, cs_w, mosi_w, miso_w;
   logic [7:0]   ptx = 8'h00, prx, b, p;
   logic [5:0]   dv;
   logic [31:0]  rd;
   int           n_mismatch = 0, total_checks = 0, n, m;
   always #5 clk_in = ~clk_in;
   // Select and MOSI lines have pull-ups; a released clock rests at the idle polarity
   assign sclk_w = pins.sclk_oe ? pins.sclk : c.clock_idle_polarity;
   assign cs_w = pins.cs_n_oe ? pins.cs_n : 1'b1;
   assign mosi_w = pins.mosi_oe ? pins.mosi : 1'b1;
   spt_transfer_control u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .apb_req_in(req),
      .apb_rsp_out(rsp), .sclk_in(s_sclk), .cs_n_in(s_cs), .mosi_in(s_mosi),
      .miso_in(miso_w), .pins_out(pins), .spi_event_out(ev));
   spt_partner u_far (.clk_in(clk_in), .sclk_in(sclk_w), .cs_n_in(cs_w), .mosi_in(mosi_w),
      .pol_in(c.clock_idle_polarity), .pha_in(c.clock_phase), .slow_in(slow),
      .tx_byte_in(ptx), .miso_out(miso_w), .rx_byte_out(prx));
   function automatic logic [7:0] ord(input logic [7:0] v, input logic lsb);
      for (int i = 0; i < 8; i++) ord[i] = lsb ? v[7-i] : v[i];
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int k;
      k = 0;
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_in);
      req.penable <= 1'b1;
      do begin
         @(posedge clk_in);
         k++;
      end while (rsp.pready !== 1'b1 && k < 20);
      rd = rsp.prdata;
      err = rsp.pslverr;
      if (k >= 20) chk("pready", 0, 1);
      req <= '0;
      @(posedge clk_in);
   endtask
   task automatic wctl();
      apb(1'b1, REG_CONTROL, {16'h0000, c});
   endtask
   task automatic base();
      c = '0;
      c.spi_enable = 1'b1;
      c.controller_role_select = 1'b1;
      c.transfer_initiate_select = 1'b1;
   endtask
   task automatic wcs(input logic lvl);
      int k;
      k = 0;
      while (cs_w !== lvl && k < 3000) begin
         @(posedge clk_in);
         k++;
      end
      if (k >= 3000) chk("select", cs_w, lvl);
   endtask
   task automatic xfer(input logic [7:0] v);
      apb(1'b1, REG_TX_HOLD, {24'h0, v});
      wcs(1'b0);
      wcs(1'b1);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      #500000;
      n_mismatch++;
      end_of_test();
   end
   initial begin
      n = $urandom(54830);
      repeat (16) @(posedge clk_in);
      arst_n_in <= 1'b1;
      @(posedge clk_in);
      apb(1'b0, REG_CONTROL, 0);
      chk("ctl reset", rd, 0);
      apb(1'b0, 12'h020, 0);
      chk("unmapped", err, 1);
      c = spt_ctl_t'($urandom);
      c.spi_enable = 1'b0;
      wctl();
      apb(1'b0, REG_CONTROL, 0);
      chk("ctl rw", rd, {16'h0000, c});
      for (int i = 0; i < 16; i++) begin
         b = 8'($urandom);
         p = 8'($urandom);
         dv = 6'(3 + $urandom % 4);
         base();
         c.clock_idle_polarity = i[0];
         c.clock_phase = i[1];
         c.lsb_first = i[2];
         c.wired_or_outputs = i[3];
         slow = i[1] ^ i[2];
         apb(1'b1, REG_DIVIDER, 32'(dv));
         wctl();
         repeat (4) @(posedge clk_in);
         chk("idle clk", sclk_w, c.clock_idle_polarity);
         ptx = p;
         xfer(b);
         chk("far byte", prx, ord(b, c.lsb_first));
         apb(1'b0, REG_RX_HOLD, 0);
         chk("rx hold", rd, ord(p, c.lsb_first));
         chk("tx event", ev, 1);
      end
      c.transfer_initiate_select = 1'b0;
      for (int z = 0; z < 2; z++) begin
         c.send_zeros_when_empty = z[0];
         wctl();
         apb(1'b0, REG_RX_HOLD, 0);
         wcs(1'b0);
         wcs(1'b1);
         chk("empty tx", prx, z ? 8'h00 : ord(b, c.lsb_first));
         chk("rx event", ev, 1);
      end
      c.transfer_initiate_select = 1'b1;
      for (int k = 0; k < 2; k++) begin
         c.rx_overflow_overwrite = k[0];
         wctl();
         apb(1'b0, REG_RX_HOLD, 0);
         ptx = p;
         xfer(b);
         ptx = ~p;
         xfer(b);
         apb(1'b0, REG_STATUS, 0);
         chk("ovf flag", rd[ST_RX_OVF], 1);
         apb(1'b0, REG_RX_HOLD, 0);
         chk("ovf data", rd, ord(k ? ~p : p, c.lsb_first));
         apb(1'b1, REG_STATUS, 32'h8);
      end
      c.loopback = 1'b1;
      wctl();
      xfer(p);
      apb(1'b0, REG_RX_HOLD, 0);
      chk("loopback", rd, p);
      for (int k = 0; k < 2; k++) begin
         base();
         c.continuous_transfer = k[0];
         wctl();
         apb(1'b1, REG_TX_HOLD, b);
         wcs(1'b0);
         apb(1'b1, REG_TX_HOLD, p);
         n = 0;
         m = 0;
         while (cs_w === 1'b0 && n < 3000) begin
            @(posedge clk_in);
            n++;
         end
         chk("span", n + 3, (k + 1) * 16 * (dv + 1));
         while (k == 0 && cs_w === 1'b1 && m < 3000) begin
            @(posedge clk_in);
            m++;
         end
         if (k == 0) chk("stall", m, 2 * (dv + 1) + 1);
         wcs(1'b1);
         chk("last byte", prx, p);
      end
      c.continuous_transfer = 1'b0;
      c.tx_fifo_purge = 1'b1;
      c.send_zeros_when_empty = 1'b1;
      wctl();
      apb(1'b1, REG_TX_HOLD, b);
      apb(1'b0, REG_STATUS, 0);
      chk("purged wr", rd[ST_TX_VALID], 0);
      wcs(1'b1);
      wcs(1'b0);
      wcs(1'b1);
      chk("purge send", prx, 0);
      base();
      c.transfer_initiate_select = 1'b0;
      c.rx_fifo_purge = 1'b1;
      wctl();
      apb(1'b0, REG_RX_HOLD, 0);
      wcs(1'b0);
      wcs(1'b1);
      apb(1'b0, REG_STATUS, 0);
      chk("purged rx", rd[ST_RX_VALID], 0);
      chk("purged ev", ev, 0);
      for (int k = 0; k < 2; k++) begin
         c = '0;
         c.spi_enable = 1'b1;
         c.slave_out_drive_en = k[0];
         wctl();
         s_cs <= 1'b0;
         for (int j = 7; j >= 0; j--) begin
            s_mosi <= b[j];
            repeat (4) @(posedge clk_in);
            s_sclk <= 1'b1;
            repeat (4) @(posedge clk_in);
            s_sclk <= 1'b0;
         end
         repeat (4) @(posedge clk_in);
         chk("slave oe", pins.miso_oe, k);
         s_cs <= 1'b1;
         repeat (8) @(posedge clk_in);
         apb(1'b0, REG_RX_HOLD, 0);
         chk("slave rx", rd, b);
      end
      end_of_test();
   end
endmodule

//--- hw/spt_transfer_control.sv
// Serial peripheral transfer controller with APB register access
// Summary of operation
// - Transmit purge held discards transmit register writes
// - Purge held keeps sending last byte or zero
// - Receive purge ignores incoming data and events
// - Receive read still starts transfer under receive purge
// - Single mode: one byte, one clock stall between
// - Continuous master mode runs until transmit empty
// - Continuous mode holds select low across bytes
// - Loopback ties own data output to input
// - Slave output driver off when drive enable clear
// - Overflow drops new byte or overwrites held byte
// - Empty transmit sends zero or repeats last byte
// - Initiate select zero: receive read starts, event full
// - Initiate select one: transmit write starts, event empty
// - Bit order field picks MSB or LSB first
// - Wired-OR mode makes data outputs open-drain
// - Polarity field sets serial clock idle level
// - Phase field sets clock pulse within bit
// - Master clock divides peripheral clock by 2 x (divider + 1)
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module spt_transfer_control (
   input  wire logic                 clk_in,
   input  wire logic                 arst_n_in,
   input  wire spt_pkg::spt_apb_req_t apb_req_in,
   output spt_pkg::spt_apb_rsp_t     apb_rsp_out,
   input  wire logic                 sclk_in,
   input  wire logic                 cs_n_in,
   input  wire logic                 mosi_in,
   input  wire logic                 miso_in,
   output spt_pkg::spt_pins_t        pins_out,
   output logic                      spi_event_out
);
   import spt_pkg::*;

   // ---------------------------------------------------------------
   // Registers and state
   // ---------------------------------------------------------------
   spt_ctl_t          ctl_r;
   logic [DIV_W-1:0]  div_r;
   logic [BYTE_W-1:0] tx_data_r;
   logic              tx_valid_r;
   logic [BYTE_W-1:0] last_tx_r;
   logic [BYTE_W-1:0] rx_data_r;
   logic              rx_valid_r;
   logic              rx_ovf_r;
   logic              start_pend_r;
   spt_state_t        state_r;
   logic [DIV_W-1:0]  div_cnt_r;
   logic              half_r;
   logic [CNT_W-1:0]  bit_cnt_r;
   logic [BYTE_W-1:0] tx_sh_r;
   logic [BYTE_W-1:0] rx_sh_r;
   logic              shift_pend_r;
   logic [2:0]        sclk_sync_r;
   logic [2:0]        cs_sync_r;
   logic [1:0]        mosi_sync_r;
   logic [1:0]        miso_sync_r;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   logic access;
   logic wr_tx;
   logic rd_rx;
   logic wr_stat;
   assign access  = apb_req_in.psel & apb_req_in.penable & apb_rsp_out.pready;
   assign wr_tx   = access & apb_req_in.pwrite & (apb_req_in.paddr == REG_TX_HOLD);
   assign rd_rx   = access & ~apb_req_in.pwrite & (apb_req_in.paddr == REG_RX_HOLD);
   assign wr_stat = access & apb_req_in.pwrite & (apb_req_in.paddr == REG_STATUS);

   // ---------------------------------------------------------------
   // Engine conditions
   // ---------------------------------------------------------------
   logic master;
   logic tick;
   logic more_data;
   logic cur_bit;
   logic rx_bit;
   logic lead;
   logic trail;
   logic m_sample;
   logic m_bit_end;
   logic s_sample;
   logic s_shift;
   logic cs_fall;
   logic sample;
   logic rx_done;
   logic load;
   logic start;
   logic [BYTE_W-1:0] rx_new;
   logic [BYTE_W-1:0] next_byte;

   assign master    = ctl_r.spi_enable & ctl_r.controller_role_select;
   assign tick      = (div_cnt_r == div_r);
   assign more_data = tx_valid_r | ctl_r.tx_fifo_purge;
   assign cur_bit   = ctl_r.lsb_first ? tx_sh_r[0] : tx_sh_r[BYTE_W-1];
   // Loopback feeds whatever this end drives back into its own receiver
   assign rx_bit    = ctl_r.loopback ? cur_bit :
                      (master ? miso_sync_r[1] : mosi_sync_r[1]);
   assign rx_new    = ctl_r.lsb_first ? {rx_bit, rx_sh_r[BYTE_W-1:1]}
                                      : {rx_sh_r[BYTE_W-2:0], rx_bit};

   // Edges of the synchronised partner clock, in idle-relative polarity
   assign lead  = (sclk_sync_r[1] ^ ctl_r.clock_idle_polarity) &
                  ~(sclk_sync_r[2] ^ ctl_r.clock_idle_polarity);
   assign trail = ~(sclk_sync_r[1] ^ ctl_r.clock_idle_polarity) &
                  (sclk_sync_r[2] ^ ctl_r.clock_idle_polarity);
   assign cs_fall = cs_sync_r[2] & ~cs_sync_r[1];

   logic slave_on;
   assign slave_on  = ctl_r.spi_enable & ~ctl_r.controller_role_select & ~cs_sync_r[1];
   assign s_sample  = slave_on & (ctl_r.clock_phase ? trail : lead);
   assign s_shift   = slave_on & shift_pend_r & (ctl_r.clock_phase ? lead : trail);
   assign m_sample  = master & (state_r == ST_SHIFT) & tick & ~half_r;
   assign m_bit_end = master & (state_r == ST_SHIFT) & tick & half_r;
   assign sample    = m_sample | s_sample;
   assign rx_done   = sample & (bit_cnt_r == LAST_BIT);

   // Master starts on a receive read or on available transmit data
   assign start = master & (state_r == ST_IDLE) &
                  (ctl_r.transfer_initiate_select ? more_data : start_pend_r);
   // Continuous master goes straight on while data remains
   logic cont_next;
   assign cont_next = m_bit_end & (bit_cnt_r == FIRST_BIT) &
                      ctl_r.continuous_transfer & more_data;
   assign load = start | cont_next |
                 (ctl_r.spi_enable & ~ctl_r.controller_role_select & cs_fall) |
                 (s_sample & (bit_cnt_r == LAST_BIT));
   // Empty transmit side falls back to zero or a repeat
   assign next_byte = tx_valid_r ? tx_data_r :
                      (ctl_r.send_zeros_when_empty ? ZERO_BYTE : last_tx_r);

   // ---------------------------------------------------------------
   // Control and divider registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ctl_r <= CTL_RESET;
         div_r <= DIV_RESET;
      end else if (access & apb_req_in.pwrite) begin
         if (apb_req_in.paddr == REG_CONTROL) begin
            ctl_r <= spt_ctl_t'(apb_req_in.pwdata[15:0]);
         end
         if (apb_req_in.paddr == REG_DIVIDER) begin
            div_r <= apb_req_in.pwdata[DIV_W-1:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Transmit holding register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tx_data_r  <= ZERO_BYTE;
         tx_valid_r <= 1'b0;
         last_tx_r  <= ZERO_BYTE;
      end else begin
         if (load) begin
            last_tx_r <= next_byte;
         end
         if (ctl_r.tx_fifo_purge) begin
            tx_valid_r <= 1'b0;
         end else if (wr_tx) begin
            tx_data_r  <= apb_req_in.pwdata[BYTE_W-1:0];
            tx_valid_r <= 1'b1;
         end else if (load) begin
            tx_valid_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Receive holding register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rx_data_r  <= ZERO_BYTE;
         rx_valid_r <= 1'b0;
         rx_ovf_r   <= 1'b0;
      end else begin
         if (ctl_r.rx_fifo_purge) begin
            rx_valid_r <= 1'b0;
         end else if (rx_done) begin
            if (!rx_valid_r || rx_overflow_keep_new()) begin
               rx_data_r  <= rx_new;
               rx_valid_r <= 1'b1;
            end
         end else if (rd_rx) begin
            rx_valid_r <= 1'b0;
         end
         // A new overflow in the clearing cycle still sets the flag
         if (rx_done & rx_valid_r & ~ctl_r.rx_fifo_purge & ~rd_rx) begin
            rx_ovf_r <= 1'b1;
         end else if (wr_stat & apb_req_in.pwdata[ST_RX_OVF]) begin
            rx_ovf_r <= 1'b0;
         end
      end
   end

   function automatic logic rx_overflow_keep_new();
      return ctl_r.rx_overflow_overwrite | rd_rx;
   endfunction

   // ---------------------------------------------------------------
   // Pending start from a receive read
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         start_pend_r <= 1'b0;
      end else if (rd_rx & ~ctl_r.transfer_initiate_select) begin
         start_pend_r <= 1'b1;
      end else if (start | ~master) begin
         start_pend_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Master sequencer and clock divider
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_r   <= ST_IDLE;
         div_cnt_r <= DIV_RESET;
         half_r    <= 1'b0;
      end else if (!master) begin
         state_r   <= ST_IDLE;
         div_cnt_r <= DIV_RESET;
         half_r    <= 1'b0;
      end else begin
         div_cnt_r <= (tick | (state_r == ST_IDLE)) ? DIV_RESET : div_cnt_r + 1'b1;
         unique case (state_r)
            ST_IDLE: begin
               half_r <= 1'b0;
               if (start) begin
                  state_r <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (tick) begin
                  half_r <= ~half_r;
               end
               if (m_bit_end & (bit_cnt_r == FIRST_BIT) & ~cont_next) begin
                  // Single mode stalls one serial clock; continuous ends here
                  state_r <= ctl_r.continuous_transfer ? ST_IDLE : ST_STALL;
               end
            end
            ST_STALL: begin
               if (tick) begin
                  half_r <= ~half_r;
                  if (half_r) begin
                     state_r <= ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Shift registers, shared by master and slave roles
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tx_sh_r      <= ZERO_BYTE;
         rx_sh_r      <= ZERO_BYTE;
         bit_cnt_r    <= FIRST_BIT;
         shift_pend_r <= 1'b0;
      end else begin
         if (sample) begin
            rx_sh_r   <= rx_new;
            bit_cnt_r <= bit_cnt_r + 1'b1;
         end
         if (load) begin
            tx_sh_r      <= next_byte;
            shift_pend_r <= 1'b0;
            if (!sample) begin
               bit_cnt_r <= FIRST_BIT;
            end
         end else if ((m_bit_end & (bit_cnt_r != FIRST_BIT)) | s_shift) begin
            tx_sh_r      <= ctl_r.lsb_first ? {1'b0, tx_sh_r[BYTE_W-1:1]}
                                            : {tx_sh_r[BYTE_W-2:0], 1'b0};
            shift_pend_r <= 1'b0;
         end else if (s_sample) begin
            shift_pend_r <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sclk_sync_r <= 3'h0;
         cs_sync_r   <= 3'h7;
         mosi_sync_r <= 2'h0;
         miso_sync_r <= 2'h0;
      end else begin
         sclk_sync_r <= {sclk_sync_r[1:0], sclk_in};
         cs_sync_r   <= {cs_sync_r[1:0], cs_n_in};
         mosi_sync_r <= {mosi_sync_r[0], mosi_in};
         miso_sync_r <= {miso_sync_r[0], miso_in};
      end
   end

   // ---------------------------------------------------------------
   // Registered pin drive
   // ---------------------------------------------------------------
   logic shifting;
   logic clk_act;
   logic drive_bit;
   assign shifting  = master & (state_r == ST_SHIFT);
   assign clk_act   = shifting & (ctl_r.clock_phase ? ~half_r : half_r);
   // Open-drain data: only ever pull low, release for a one
   assign drive_bit = ctl_r.wired_or_outputs ? ~cur_bit : 1'b1;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pins_out <= '0;
      end else begin
         pins_out.sclk    <= ctl_r.clock_idle_polarity ^ clk_act;
         pins_out.sclk_oe <= master;
         pins_out.cs_n    <= ~shifting;
         pins_out.cs_n_oe <= master;
         pins_out.mosi    <= ctl_r.wired_or_outputs ? 1'b0 : cur_bit;
         pins_out.mosi_oe <= master & drive_bit;
         pins_out.miso    <= ctl_r.wired_or_outputs ? 1'b0 : cur_bit;
         pins_out.miso_oe <= slave_on & ctl_r.slave_out_drive_en & drive_bit;
      end
   end

   // ---------------------------------------------------------------
   // Event level
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         spi_event_out <= 1'b0;
      end else begin
         spi_event_out <= ctl_r.spi_enable & ~ctl_r.rx_fifo_purge &
                          (ctl_r.transfer_initiate_select ? ~tx_valid_r : rx_valid_r);
      end
   end

   // ---------------------------------------------------------------
   // APB slave: one wait-free access cycle, answer prepared in setup
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] rd_val;
   logic              rd_ok;
   always_comb begin
      rd_val = '0;
      rd_ok  = 1'b1;
      unique case (apb_req_in.paddr)
         REG_STATUS: begin
            rd_val[ST_TX_VALID] = tx_valid_r;
            rd_val[ST_RX_VALID] = rx_valid_r;
            rd_val[ST_BUSY]     = (state_r != ST_IDLE) | slave_on;
            rd_val[ST_RX_OVF]   = rx_ovf_r;
         end
         REG_RX_HOLD: rd_val[BYTE_W-1:0] = rx_data_r;
         REG_TX_HOLD: rd_val = '0;
         REG_DIVIDER: rd_val[DIV_W-1:0] = div_r;
         REG_CONTROL: rd_val[15:0] = ctl_r;
         default:     rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         apb_rsp_out <= '0;
      end else if (apb_req_in.psel & ~apb_req_in.penable) begin
         apb_rsp_out.pready  <= 1'b1;
         apb_rsp_out.pslverr <= ~rd_ok;
         apb_rsp_out.prdata  <= rd_val;
      end else begin
         apb_rsp_out.pready  <= 1'b0;
         apb_rsp_out.pslverr <= 1'b0;
      end
   end

endmodule

//--- inc/spt_pkg.sv
// Shared constants, register map and types for the serial transfer controller
package spt_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int BYTE_W = 8;
   localparam int DIV_W  = 6;
   localparam int CNT_W  = 3;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] REG_STATUS  = 12'h000;
   localparam logic [ADDR_W-1:0] REG_RX_HOLD = 12'h004;
   localparam logic [ADDR_W-1:0] REG_TX_HOLD = 12'h008;
   localparam logic [ADDR_W-1:0] REG_DIVIDER = 12'h00c;
   localparam logic [ADDR_W-1:0] REG_CONTROL = 12'h010;

   // ---------------------------------------------------------------
   // Reset values and fixed data
   // ---------------------------------------------------------------
   localparam logic [15:0]       CTL_RESET  = 16'h0000;
   localparam logic [DIV_W-1:0]  DIV_RESET  = 6'h00;
   localparam logic [BYTE_W-1:0] ZERO_BYTE  = 8'h00;
   localparam logic [CNT_W-1:0]  LAST_BIT   = 3'h7;
   localparam logic [CNT_W-1:0]  FIRST_BIT  = 3'h0;

   // Status register bit positions
   localparam int ST_TX_VALID = 0;
   localparam int ST_RX_VALID = 1;
   localparam int ST_BUSY     = 2;
   localparam int ST_RX_OVF   = 3;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0] irq_mode;
      logic       tx_fifo_purge;
      logic       rx_fifo_purge;
      logic       continuous_transfer;
      logic       loopback;
      logic       slave_out_drive_en;
      logic       rx_overflow_overwrite;
      logic       send_zeros_when_empty;
      logic       transfer_initiate_select;
      logic       lsb_first;
      logic       wired_or_outputs;
      logic       clock_idle_polarity;
      logic       clock_phase;
      logic       controller_role_select;
      logic       spi_enable;
   } spt_ctl_t;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } spt_apb_req_t;

   typedef struct packed {
      logic              pready;
      logic              pslverr;
      logic [DATA_W-1:0] prdata;
   } spt_apb_rsp_t;

   typedef struct packed {
      logic sclk;
      logic sclk_oe;
      logic cs_n;
      logic cs_n_oe;
      logic mosi;
      logic mosi_oe;
      logic miso;
      logic miso_oe;
   } spt_pins_t;

   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_STALL} spt_state_t;

endpackage
